/* core/fifo_flag_offset_and_status.sv */
// Offset registers and standard-mode status flags of a deep dual-port FIFO.
// Assumes the write and read clocks and the control pins arrive as asynchronous pins,
// sampled on ref_clk_i; the offset load port comes from logic on ref_clk_i.
`timescale 1ns/10ps
`default_nettype none
module fifo_flag_offset_and_status
(
   input  wire logic                                ref_clk_i,              // 200 MHz clock.
   input  wire logic                                rst_i,                  // Sync reset, high.
   input  wire logic                                master_reset_i,         // Pin, high.
   input  wire logic                                offset_load_select_i,   // Pin, at reset.
   input  wire logic                                default_offset_pick0_i, // Pin, at reset.
   input  wire logic                                default_offset_pick1_i, // Pin, at reset.
   input  wire logic                                flag_timing_select_i,   // Pin, at reset.
   input  wire logic                                write_clk_i,            // Write clock pin.
   input  wire logic                                read_clk_i,             // Read clock pin.
   input  wire logic                                write_en_i,             // Pin, high.
   input  wire logic                                read_en_i,              // Pin, high.
   input  wire logic                                offset_write_i,         // Load pulse.
   input  wire logic [fifo_flag_pkg::OFFSET_W-1:0]  empty_offset_i,         // New n.
   input  wire logic [fifo_flag_pkg::OFFSET_W-1:0]  full_offset_i,          // New m.
   input  wire logic                                offset_read_i,          // Readback pulse.
   input  wire logic                                offset_read_sel_i,      // 0 n, 1 m.
   output logic [fifo_flag_pkg::DOUT_W-1:0]         parallel_data_out_o,    // Readback data.
   output logic                                     serial_mode_o,          // Serial load chosen.
   output logic                                     sync_flags_o,           // Sync flag timing.
   output logic [fifo_flag_pkg::COUNT_W-1:0]        word_count_o,           // Stored words.
   output logic                                     empty_flag_n_o,         // Low when empty.
   output logic                                     almost_empty_flag_n_o,  // Low at n or less.
   output logic                                     half_full_flag_n_o,     // Low above half.
   output logic                                     almost_full_flag_n_o,   // Low near full.
   output logic                                     full_flag_n_o           // Low when full.
);

   logic                                mr_s;        // Filtered master reset.
   logic                                ld_s;        // Filtered load select.
   logic                                p0_s;        // Filtered pick0.
   logic                                p1_s;        // Filtered pick1.
   logic                                ts_s;        // Filtered timing select.
   logic                                wclk_s;      // Filtered write clock.
   logic                                rclk_s;      // Filtered read clock.
   logic                                wen_s;       // Filtered write enable.
   logic                                ren_s;       // Filtered read enable.
   logic                                wclk_d_r;    // Previous write clock level.
   logic                                rclk_d_r;    // Previous read clock level.
   logic                                w_edge;      // Write clock rising edge.
   logic                                r_edge;      // Read clock rising edge.
   logic [fifo_flag_pkg::OFFSET_W-1:0]  empty_off_r; // Empty offset n.
   logic [fifo_flag_pkg::OFFSET_W-1:0]  full_off_r;  // Full offset m.
   logic [fifo_flag_pkg::COUNT_W-1:0]   count_r;     // Stored word count.
   logic [fifo_flag_pkg::COUNT_W-1:0]   count_nxt;   // Count after this cycle's edges.
   logic                                do_write;    // A word is written now.
   logic                                do_read;     // A word is read now.
   logic                                af_cond;     // Count is in the almost-full band.
   logic                                ae_cond;     // Count is in the almost-empty band.
   logic [fifo_flag_pkg::COUNT_W-1:0]   af_thresh;   // Depth minus m.

   logic [8:0] pins_raw; // All asynchronous pins, one synchroniser each.
   logic [8:0] pins_s;   // Their filtered levels.

   assign pins_raw = {master_reset_i, offset_load_select_i, default_offset_pick0_i,
                      default_offset_pick1_i, flag_timing_select_i, write_clk_i,
                      read_clk_i, write_en_i, read_en_i};
   assign {mr_s, ld_s, p0_s, p1_s, ts_s, wclk_s, rclk_s, wen_s, ren_s} = pins_s;

   // One synchroniser per pin; none of their first stages is seen here.
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi = gi + 1)
      begin : g_sync
         pin_sync3 u_sync
         (
            .ref_clk_i (ref_clk_i),
            .rst_i     (rst_i),
            .pin_i     (pins_raw[gi]),
            .level_o   (pins_s[gi])
         );
      end
   endgenerate

   // Edge detectors on the filtered port clocks.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         wclk_d_r <= 1'b0;
         rclk_d_r <= 1'b0;
      end
      else
      begin
         wclk_d_r <= wclk_s;
         rclk_d_r <= rclk_s;
      end
   end

   assign w_edge = wclk_s & ~wclk_d_r;
   assign r_edge = rclk_s & ~rclk_d_r;

   // Writes into a full FIFO and reads from an empty one are ignored.
   assign do_write = w_edge & wen_s & (count_r != fifo_flag_pkg::COUNT_FULL);
   assign do_read  = r_edge & ren_s & (count_r != fifo_flag_pkg::COUNT_ZERO);

   // Next count; a simultaneous write and read leave it unchanged.
   always_comb
   begin
      count_nxt = count_r;
      if (do_write & ~do_read)
      begin
         count_nxt = count_r + fifo_flag_pkg::COUNT_ONE;
      end
      else if (do_read & ~do_write)
      begin
         count_nxt = count_r - fifo_flag_pkg::COUNT_ONE;
      end
   end

   // Band tests on the count that the flags will reflect.
   assign af_thresh = fifo_flag_pkg::COUNT_FULL - {1'b0, full_off_r};
   assign af_cond   = (count_nxt >= af_thresh);
   assign ae_cond   = (count_nxt <= {1'b0, empty_off_r});

   // Mode straps are caught while master reset is held, so a pin that moves
   // afterwards has no effect until the next master reset.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         serial_mode_o <= 1'b0;
         sync_flags_o  <= 1'b0;
      end
      else if (mr_s)
      begin
         serial_mode_o <= ld_s;
         sync_flags_o  <= ts_s;
      end
   end

   // Offset registers: preset at master reset, then parallel loads at any time.
   // The host keeps values within 0..D-1; the width admits nothing larger.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         empty_off_r <= fifo_flag_pkg::preset_offset(fifo_flag_pkg::DEPTH_CLASS, 3'h0);
         full_off_r  <= fifo_flag_pkg::preset_offset(fifo_flag_pkg::DEPTH_CLASS, 3'h0);
      end
      else if (mr_s)
      begin
         // Both offsets take the same preset, whatever load method is chosen.
         empty_off_r <= fifo_flag_pkg::preset_offset(fifo_flag_pkg::DEPTH_CLASS,
                                                     {ld_s, p1_s, p0_s});
         full_off_r  <= fifo_flag_pkg::preset_offset(fifo_flag_pkg::DEPTH_CLASS,
                                                     {ld_s, p1_s, p0_s});
      end
      else if (offset_write_i)
      begin
         empty_off_r <= empty_offset_i;
         full_off_r  <= full_offset_i;
      end
   end

   // Readback exists only on the parallel output; there is no serial path.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         parallel_data_out_o <= '0;
      end
      else if (offset_read_i)
      begin
         parallel_data_out_o <= offset_read_sel_i ?
                                fifo_flag_pkg::DOUT_W'(full_off_r) :
                                fifo_flag_pkg::DOUT_W'(empty_off_r);
      end
   end

   // Word count, cleared by master reset.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || mr_s)
      begin
         count_r <= fifo_flag_pkg::COUNT_ZERO;
      end
      else
      begin
         count_r <= count_nxt;
      end
   end

   assign word_count_o = count_r;

   // Empty, half-full and full follow the count every cycle.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || mr_s)
      begin
         empty_flag_n_o     <= fifo_flag_pkg::EMPTY_RST;
         half_full_flag_n_o <= fifo_flag_pkg::HALF_FULL_RST;
         full_flag_n_o      <= fifo_flag_pkg::FULL_RST;
      end
      else
      begin
         empty_flag_n_o     <= (count_nxt != fifo_flag_pkg::COUNT_ZERO);
         half_full_flag_n_o <= ~(count_nxt > fifo_flag_pkg::COUNT_HALF);
         full_flag_n_o      <= (count_nxt != fifo_flag_pkg::COUNT_FULL);
      end
   end

   // Almost-full: in sync mode it moves only on write edges; in async mode
   // a write edge can only assert it and a read edge can only release it.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || mr_s)
      begin
         almost_full_flag_n_o <= fifo_flag_pkg::ALMOST_FULL_RST;
      end
      else if (sync_flags_o)
      begin
         if (w_edge)
         begin
            almost_full_flag_n_o <= ~af_cond;
         end
      end
      else if (w_edge && af_cond)
      begin
         almost_full_flag_n_o <= 1'b0;
      end
      else if (r_edge && !af_cond)
      begin
         almost_full_flag_n_o <= 1'b1;
      end
   end

   // Almost-empty: the mirror image, with the roles of the two edges swapped.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || mr_s)
      begin
         almost_empty_flag_n_o <= fifo_flag_pkg::ALMOST_EMPTY_RST;
      end
      else if (sync_flags_o)
      begin
         if (r_edge)
         begin
            almost_empty_flag_n_o <= ~ae_cond;
         end
      end
      else if (r_edge && ae_cond)
      begin
         almost_empty_flag_n_o <= 1'b0;
      end
      else if (w_edge && !ae_cond)
      begin
         almost_empty_flag_n_o <= 1'b1;
      end
   end

endmodule
`default_nettype wire

/* core/fifo_flag_pkg.sv */
// Constants, default offset table and depth class for the FIFO offset and status flag block.
// Assumes a single 200 MHz reference clock; every consumer names items as fifo_flag_pkg::name.
// What this block does
// - Master reset latches pins, picks preset offset.
// - Shallow-depth preset table for both offsets.
// - Mid and deep preset tables for offsets.
// - Load-select at reset picks serial or parallel.
// - Either load method also loads preset offset.
// - Offsets read back only on parallel output.
// - Offsets reprogrammable after reset, range 0..D-1.
// - Sync mode: each almost flag on own edge.
// - Async almost-full: low on write, high on read.
// - Async almost-empty: low on read, high on write.
// - Almost-empty low for count zero through n.
// - Half-full low above half the depth.
// - Almost-full low from depth minus m upward.
// - Empty low at zero, full low at depth.
package fifo_flag_pkg;

   // Capacity of the part this block is built for.
   localparam int unsigned FIFO_DEPTH = 131072;
   // Word count runs 0..FIFO_DEPTH, so it needs one bit above the offset width.
   localparam int unsigned COUNT_W    = 18;
   // Offsets run 0..FIFO_DEPTH-1.
   localparam int unsigned OFFSET_W   = 17;
   // Width of the parallel output port used for offset readback.
   localparam int unsigned DOUT_W     = 36;

   // Count thresholds at counter width.
   localparam logic [COUNT_W-1:0] COUNT_FULL = 18'h20000;
   localparam logic [COUNT_W-1:0] COUNT_HALF = 18'h10000;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 18'h00000;
   localparam logic [COUNT_W-1:0] COUNT_ONE  = 18'h00001;

   // Depth bounds that separate the three preset tables.
   localparam int unsigned SHALLOW_MAX = 2048;
   localparam int unsigned MID_MAX     = 32768;

   // Flag reset levels (active low flags): empty and almost-empty asserted.
   localparam logic EMPTY_RST        = 1'b0;
   localparam logic ALMOST_EMPTY_RST = 1'b0;
   localparam logic HALF_FULL_RST    = 1'b1;
   localparam logic ALMOST_FULL_RST  = 1'b1;
   localparam logic FULL_RST         = 1'b1;

   // Which preset table applies to this depth.
   typedef enum logic [1:0] {DEPTH_SHALLOW, DEPTH_MID, DEPTH_DEEP} depth_class_t;

   localparam depth_class_t DEPTH_CLASS = (FIFO_DEPTH <= SHALLOW_MAX) ? DEPTH_SHALLOW :
                                          (FIFO_DEPTH <= MID_MAX)     ? DEPTH_MID : DEPTH_DEEP;

   // Preset offset chosen by {load select, pick1, pick0}.
   function automatic logic [OFFSET_W-1:0] preset_offset(input depth_class_t cls,
                                                         input logic [2:0]   sel);
      logic [OFFSET_W-1:0] v;
      v = 17'h0007f;
      case (cls)
         DEPTH_SHALLOW:
         begin
            case (sel)
               3'h2:    v = 17'h001ff;
               3'h1:    v = 17'h000ff;
               3'h0:    v = 17'h0007f;
               3'h3:    v = 17'h0003f;
               3'h4:    v = 17'h0001f;
               3'h6:    v = 17'h0000f;
               3'h5:    v = 17'h00007;
               default: v = 17'h00003;
            endcase
         end
         DEPTH_MID:
         begin
            case (sel)
               3'h4:    v = 17'h003ff;
               3'h2:    v = 17'h001ff;
               3'h1:    v = 17'h000ff;
               3'h0:    v = 17'h0007f;
               3'h3:    v = 17'h0003f;
               3'h6:    v = 17'h0001f;
               3'h5:    v = 17'h0000f;
               default: v = 17'h00007;
            endcase
         end
         default:
         begin
            case (sel)
               3'h2:    v = 17'h03fff;
               3'h1:    v = 17'h01fff;
               3'h3:    v = 17'h00fff;
               3'h6:    v = 17'h007ff;
               3'h4:    v = 17'h003ff;
               3'h5:    v = 17'h001ff;
               3'h7:    v = 17'h000ff;
               default: v = 17'h0007f;
            endcase
         end
      endcase
      return v;
   endfunction

endpackage

/* core/pin_sync3.sv */
// Three-stage synchroniser for one asynchronous pin with agreement filter.
// Assumes the pin is quiet for at least two reference clocks between changes.
`timescale 1ns/10ps
`default_nettype none
module pin_sync3
(
   input  wire logic ref_clk_i, // Reference clock.
   input  wire logic rst_i,     // Synchronous reset, active high.
   input  wire logic pin_i,     // Raw pin level.
   output logic      level_o    // Filtered level, registered.
);

   logic s1_r; // First stage, read only by the second stage.
   logic s2_r; // Second stage.
   logic s3_r; // Third stage.

   // The level is accepted only once stages two and three agree, so a
   // metastable first stage never reaches the logic beyond.
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         s1_r    <= 1'b0;
         s2_r    <= 1'b0;
         s3_r    <= 1'b0;
         level_o <= 1'b0;
      end
      else
      begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
         begin
            level_o <= s3_r;
         end
      end
   end

endmodule
`default_nettype wire

/* testbench/fifo_flag_sva.sv */
// Checker for the FIFO word count and status flags.
// Assumes it is bound to the block's top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fifo_flag_sva
(
   input wire logic                              ref_clk_i,             // Reference clock.
   input wire logic                              rst_i,                 // Sync reset, high.
   input wire logic                              write_clk_i,           // Write clock pin.
   input wire logic                              read_clk_i,            // Read clock pin.
   input wire logic                              sync_flags_o,          // Sync flag timing.
   input wire logic [fifo_flag_pkg::COUNT_W-1:0] word_count_o,          // Stored words.
   input wire logic                              empty_flag_n_o,        // Empty, low.
   input wire logic                              almost_empty_flag_n_o, // Almost empty, low.
   input wire logic                              half_full_flag_n_o,    // Half full, low.
   input wire logic                              almost_full_flag_n_o,  // Almost full, low.
   input wire logic                              full_flag_n_o          // Full, low.
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   // A port pin three cycles back means its event is still working through the synchroniser.
   // Three is loose on purpose, since pulses stay high four cycles.
   sequence s_write_seen;
      $past(write_clk_i, 3);
   endsequence
   sequence s_read_seen;
      $past(read_clk_i, 3);
   endsequence

   a_empty_count: assert property (empty_flag_n_o == (word_count_o != fifo_flag_pkg::COUNT_ZERO))
      else $error("empty flag disagrees with word count");
   a_full_count: assert property (full_flag_n_o == (word_count_o != fifo_flag_pkg::COUNT_FULL))
      else $error("full flag disagrees with word count");
   a_half_count: assert property (half_full_flag_n_o == !(word_count_o > fifo_flag_pkg::COUNT_HALF))
      else $error("half full flag disagrees with word count");
   a_reset_flags: assert property (disable iff (1'b0) rst_i |=> word_count_o == '0
      && !empty_flag_n_o && !almost_empty_flag_n_o && half_full_flag_n_o
      && almost_full_flag_n_o && full_flag_n_o)
      else $error("flags wrong after reset");
   a_count_cause: assert property (($changed(word_count_o) && word_count_o != '0)
      |-> (s_write_seen or s_read_seen))
      else $error("word count moved without a port edge");
   a_af_sync_edge: assert property ((sync_flags_o && $fell(almost_full_flag_n_o)) |-> s_write_seen)
      else $error("sync almost full moved without a write edge");
   a_ae_sync_edge: assert property ((sync_flags_o && $rose(almost_empty_flag_n_o)) |-> s_read_seen)
      else $error("sync almost empty moved without a read edge");
   a_ae_async_rise: assert property ((!sync_flags_o && $rose(almost_empty_flag_n_o))
      |-> s_write_seen)
      else $error("async almost empty rose without a write edge");
   a_af_async_fall: assert property ((!sync_flags_o && $fell(almost_full_flag_n_o))
      |-> s_write_seen)
      else $error("async almost full fell without a write edge");
endmodule
`default_nettype wire

/* testbench/host_port_model.sv */
// Host logic on the write and read ports: makes port clock pulses with enables.
// Assumes a caller at one ref clock; each pulse phase lasts HOLD ref clocks.
`timescale 1ns/10ps
`default_nettype none
module host_port_model
(
   input  wire logic ref_clk_i,   // Reference clock that paces the pulses.
   output logic      write_clk_o, // Write clock pin.
   output logic      read_clk_o,  // Read clock pin.
   output logic      write_en_o,  // Write enable pin.
   output logic      read_en_o    // Read enable pin.
);
   // Four cycles a phase covers the two-cycle minimum plus some margin.
   localparam int HOLD = 4;
   logic [1:0] clk_r; // Index 0 is the write port, 1 the read port.
   logic [1:0] en_r;  // Enables, inverted between pulses so no stale level lingers.

   assign write_clk_o = clk_r[0];
   assign read_clk_o  = clk_r[1];
   assign write_en_o  = en_r[0];
   assign read_en_o   = en_r[1];

   initial
   begin
      clk_r = 2'h0;
      en_r  = 2'h0;
   end

   // One rising edge on a port; the enable settles a phase before the clock rises.
   task automatic port_edge(input int unsigned port, input logic en);
      en_r[port] = en;
      repeat (HOLD) @(posedge ref_clk_i);
      #1;
      clk_r[port] = 1'b1;
      repeat (HOLD) @(posedge ref_clk_i);
      #1;
      clk_r[port] = 1'b0;
      en_r[port]  = ~en;
      repeat (HOLD) @(posedge ref_clk_i);
      #1;
   endtask
endmodule
`default_nettype wire

/* testbench/tb_fifo_flag_offset_and_status.sv */
// Self-checking bench for the FIFO offset registers and status flags.
// Assumes the host model drives the port pins and the bench drives all other pins.
`timescale 1ns/10ps
`default_nettype none
module tb_fifo_flag_offset_and_status;
   logic        ref_clk_i, rst_i, master_reset_i, offset_write_i, offset_read_i, read_sel;
   logic        ld_pin, pick1_pin, pick0_pin, timing_pin; // Pins latched at master reset.
   logic [16:0] empty_offset_i, full_offset_i;
   logic        write_clk, read_clk, write_en, read_en;   // From the host model.
   logic [35:0] dout;
   logic        serial_mode_o, sync_flags_o, ef_n, ae_n, hf_n, af_n, ff_n;
   logic [17:0] word_count_o;
   int          failures;
   int          check_count;
   // Deep-table presets indexed by {load select, pick1, pick0}.
   logic [35:0] preset_exp [8] = '{36'h7f, 36'h1fff, 36'h3fff, 36'hfff, 36'h3ff, 36'h1ff,
                                   36'h7ff, 36'hff};

   fifo_flag_offset_and_status fifo_flag_offset_and_status_i (.ref_clk_i(ref_clk_i),
      .rst_i(rst_i), .master_reset_i(master_reset_i), .offset_load_select_i(ld_pin),
      .default_offset_pick0_i(pick0_pin), .default_offset_pick1_i(pick1_pin),
      .flag_timing_select_i(timing_pin), .write_clk_i(write_clk), .read_clk_i(read_clk),
      .write_en_i(write_en), .read_en_i(read_en), .offset_write_i(offset_write_i),
      .empty_offset_i(empty_offset_i), .full_offset_i(full_offset_i),
      .offset_read_i(offset_read_i), .offset_read_sel_i(read_sel), .parallel_data_out_o(dout),
      .serial_mode_o(serial_mode_o), .sync_flags_o(sync_flags_o), .word_count_o(word_count_o),
      .empty_flag_n_o(ef_n), .almost_empty_flag_n_o(ae_n), .half_full_flag_n_o(hf_n),
      .almost_full_flag_n_o(af_n), .full_flag_n_o(ff_n));
   host_port_model host_port_model_i (.ref_clk_i(ref_clk_i), .write_clk_o(write_clk),
      .read_clk_o(read_clk), .write_en_o(write_en), .read_en_o(read_en));

   // Free-running 200 MHz reference clock.
   initial
   begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   // Compares one value; four-state compare so an unknown never passes.
   task automatic chk_val(input string what, input logic [35:0] exp, input logic [35:0] got);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Flags are compared as {empty, almost empty, half, almost full, full}, all active low.
   task automatic chk_flags(input string what, input logic [4:0] exp);
      chk_val(what, {31'h0, exp}, {31'h0, ef_n, ae_n, hf_n, af_n, ff_n});
   endtask
   // Waits n edges and steps just past the last one.
   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   // Readback pulse; the data appears at the edge that takes it.
   task automatic read_back(input logic sel, input logic [35:0] exp, input string what);
      read_sel      = sel;
      offset_read_i = 1'b1;
      cycles(1);
      offset_read_i = 1'b0;
      chk_val(what, exp, dout);
      // One idle edge, so a readback that follows raises the strobe afresh.
      cycles(1);
   endtask
   // Parallel load of both offsets in one pulse.
   task automatic load_offsets(input logic [16:0] n, input logic [16:0] m);
      empty_offset_i = n;
      full_offset_i  = m;
      offset_write_i = 1'b1;
      cycles(1);
      offset_write_i = 1'b0;
   endtask
   // Master reset with a load attempt inside it, which must be ignored.
   task automatic mreset(input logic [2:0] sel, input logic flag_timing_select);
      {ld_pin, pick1_pin, pick0_pin} = sel;
      timing_pin     = flag_timing_select;
      master_reset_i = 1'b1;
      cycles(6);
      load_offsets(17'h5, 17'h5);
      cycles(2);
      master_reset_i = 1'b0;
      cycles(8);
   endtask
   // Repeated port edges: port 0 writes, port 1 reads.
   task automatic edges(input int unsigned port, input logic en, input int n);
      repeat (n) host_port_model_i.port_edge(port, en);
   endtask
   // Single exit for both the normal end and the watchdog.
   task automatic wrap_up;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog: the run needs about 400 cycles, so 10000 means a hang.
   initial
   begin
      #50000;
      failures++;
      wrap_up();
   end

   // Main sequence of scenarios.
   initial
   begin
      failures = 0;
      check_count = 0;
      {rst_i, master_reset_i, offset_write_i, offset_read_i, read_sel} = 5'h10;
      {ld_pin, pick1_pin, pick0_pin, timing_pin} = 4'h0;
      empty_offset_i = 17'h0;
      full_offset_i  = 17'h0;
      repeat (3) @(posedge ref_clk_i);
      #1;
      rst_i = 1'b0;
      cycles(5);
      chk_val("count after reset", 36'h0, {18'h0, word_count_o});
      chk_flags("flags after reset", 5'h07);
      read_back(1'b0, 36'h7f, "offset after reset");
      // Every preset selection, with the mode pins latched alongside.
      for (int s = 0; s < 8; s++)
      begin
         mreset(s[2:0], s[0]);
         read_back(1'b0, preset_exp[s], "preset empty offset");
         read_back(1'b1, preset_exp[s], "preset full offset");
         chk_val("serial select", {35'h0, s[2]}, {35'h0, serial_mode_o});
         chk_val("sync select", {35'h0, s[0]}, {35'h0, sync_flags_o});
      end
      // Synchronous flag timing with n = 2 and the largest legal m.
      mreset(3'h0, 1'b1);
      load_offsets(17'h2, 17'h1ffff);
      read_back(1'b0, 36'h2, "loaded empty offset");
      read_back(1'b1, 36'h1ffff, "loaded full offset");
      edges(0, 1'b1, 1);
      chk_flags("sync one word", 5'h15);
      edges(0, 1'b1, 2);
      chk_flags("sync three words", 5'h15);
      edges(1, 1'b0, 1);
      chk_val("count after idle read", 36'h3, {18'h0, word_count_o});
      chk_flags("sync idle read edge", 5'h1d);
      edges(1, 1'b1, 4);
      chk_val("count after read when empty", 36'h0, {18'h0, word_count_o});
      chk_flags("sync drained", 5'h05);
      edges(0, 1'b0, 1);
      chk_flags("sync idle write edge", 5'h07);
      // Asynchronous flag timing with the same offsets.
      mreset(3'h0, 1'b0);
      load_offsets(17'h2, 17'h1ffff);
      edges(0, 1'b1, 3);
      chk_flags("async three words", 5'h1d);
      edges(1, 1'b1, 1);
      chk_flags("async two words", 5'h15);
      edges(1, 1'b1, 2);
      chk_flags("async drained", 5'h07);
      wrap_up();
   end
endmodule

bind fifo_flag_offset_and_status fifo_flag_sva fifo_flag_sva_i (.ref_clk_i(ref_clk_i),
   .rst_i(rst_i), .write_clk_i(write_clk_i), .read_clk_i(read_clk_i),
   .sync_flags_o(sync_flags_o), .word_count_o(word_count_o), .empty_flag_n_o(empty_flag_n_o),
   .almost_empty_flag_n_o(almost_empty_flag_n_o), .half_full_flag_n_o(half_full_flag_n_o),
   .almost_full_flag_n_o(almost_full_flag_n_o), .full_flag_n_o(full_flag_n_o));
`default_nettype wire
